// [logic/nvap_cfg.svh]
// constants for the nvm access and protection block
`ifndef NVAP_CFG_SVH
`define NVAP_CFG_SVH

// ----------------------------------------------------------------------
// What this block does
// (RULE1) data flash is written a byte at a time, with its erase automatic
// (RULE2) every write and erase is timed by an internal cycle counter
// (RULE3) read protection refuses programmer reads and writes of that memory
// (RULE4) software writes and erases to write-protected areas are blocked
// (RULE5) a blocked write leaves memory unchanged and sets the error flag, except a write to the reserved word
// (RULE6) protection bits clear only through a programmer bulk erase
// (RULE7) bulk erase is accepted only from the programming port
// (RULE8) config bulk erase on a read-protected part erases everything
// (RULE9) region select clear maps the address onto program flash words
// (RULE10) pointer reads program flash at 0x8000 up; pointer writes refused
// (RULE11) region select set puts data flash at 0x7000-0x70FF, pointer too
// (RULE12) region select set decodes user id, ids, config and info area
// (RULE13) software writes two unlock keys, then the start bit, uninterrupted
// (RULE14) read-start bit clears itself once the data pair is loaded
// (RULE15) finished erase sets the done flag and interrupts when enabled
// (RULE16) erase of a protected address clears start and is skipped
// (RULE17) reserved word between user id and revision reads zero
// ----------------------------------------------------------------------

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define NVAP_REG_CTRL 4'h0
`define NVAP_REG_STAT 4'h1
`define NVAP_REG_MASK 4'h2
`define NVAP_REG_ADRL 4'h3
`define NVAP_REG_ADRH 4'h4
`define NVAP_REG_DATL 4'h5
`define NVAP_REG_DATH 4'h6
`define NVAP_REG_KEY 4'h7
`define NVAP_REG_PROT 4'h8

// control fields
`define NVAP_CTRL_RD 0
`define NVAP_CTRL_WR 1
`define NVAP_CTRL_WREN 2
`define NVAP_CTRL_FREE 3
`define NVAP_CTRL_ERR 4
`define NVAP_CTRL_RSEL 6

// status and mask fields
`define NVAP_STAT_DONE 0
`define NVAP_STAT_ERR 1

// unlock keys
`define NVAP_KEY1 8'h55
`define NVAP_KEY2 8'haa

// ----------------------------------------------------------------------
// address map
// ----------------------------------------------------------------------
`define NVAP_PFM_TOP 15'h3fff
`define NVAP_UID_HI 15'h0003
`define NVAP_RSV 15'h0004
`define NVAP_REV 15'h0005
`define NVAP_DEVID 15'h0006
`define NVAP_CFG_LO 15'h0007
`define NVAP_CFG_HI 15'h000b
`define NVAP_INFO_LO 15'h0100
`define NVAP_INFO_HI 15'h02ff
`define NVAP_DFM_LO 15'h7000
`define NVAP_DFM_HI 15'h70ff

// protection bits, active low, inside the config words
`define NVAP_CFG_WP_WORD 3
`define NVAP_CFG_CP_WORD 4
`define NVAP_CP_BIT 0
`define NVAP_CPD_BIT 1

// programmer commands
`define NVAP_PG_READ 2'h0
`define NVAP_PG_WRITE 2'h1
`define NVAP_PG_BULK 2'h2
`define NVAP_PG_BULK_CFG 2'h3

// reset values
`define NVAP_WORD_ERASED 14'h3fff
`define NVAP_BYTE_ERASED 8'hff

// timing
`define NVAP_CLK_MHZ 125
`define NVAP_T_PROG_US 2000
`define NVAP_T_BULK_US 5000

`endif

// [logic/nvap_pkg.sv]
// types for the nvm access and protection block
package nvap_pkg;

  typedef enum logic [3:0] {
    RG_NONE, RG_PFM, RG_UID, RG_RSV, RG_REV, RG_DEVID, RG_CFG, RG_INFO,
    RG_DFM
  } nvap_region_t;

  typedef enum logic {ST_IDLE, ST_BUSY} nvap_state_t;

  typedef enum logic [1:0] {
    JOB_WRITE, JOB_ERASE, JOB_BULK, JOB_BULK_CFG
  } nvap_job_t;

endpackage

// [logic/nvap_decode.sv]
// address decoder for the nvm regions
`timescale 1ns/1ps
`include "nvap_cfg.svh"

module nvap_decode
  import nvap_pkg::*;
(
  // address in
  input wire logic region_sel,
  input wire logic [14:0] addr,
  // decode out
  output nvap_region_t region,
  output logic writable
);

  always_comb
  begin
    region = RG_NONE;
    writable = 1'b0;
    if (!region_sel)
    begin
      if (addr <= `NVAP_PFM_TOP)
      begin
        region = RG_PFM; // RULE9
        writable = 1'b1;
      end
    end
    else if (addr <= `NVAP_UID_HI)
    begin
      region = RG_UID; // RULE12
      writable = 1'b1;
    end
    else if (addr == `NVAP_RSV)
      region = RG_RSV; // RULE17
    else if (addr == `NVAP_REV)
      region = RG_REV; // RULE12
    else if (addr == `NVAP_DEVID)
      region = RG_DEVID; // RULE12
    else if (addr >= `NVAP_CFG_LO && addr <= `NVAP_CFG_HI)
    begin
      region = RG_CFG; // RULE12
      writable = 1'b1;
    end
    else if (addr >= `NVAP_INFO_LO && addr <= `NVAP_INFO_HI)
      region = RG_INFO; // RULE12
    else if (addr >= `NVAP_DFM_LO && addr <= `NVAP_DFM_HI)
    begin
      region = RG_DFM; // RULE11
      writable = 1'b1;
    end
  end

endmodule

// [logic/nvap_top.sv]
// nvm access controller with protection, pointer port and programmer port
//
// Our own choices: the plain strobed port and the address map.
`timescale 1ns/1ps
`include "nvap_cfg.svh"

module nvap_top
  import nvap_pkg::*;
#(
  parameter int PFM_WORDS = 16384,
  parameter int DFM_BYTES = 256,
  parameter int ROW_WORDS = 32,
  parameter int PROG_CYCLES = `NVAP_T_PROG_US * `NVAP_CLK_MHZ,
  parameter int BULK_CYCLES = `NVAP_T_BULK_US * `NVAP_CLK_MHZ,
  // identity words: values are arbitrary
  parameter logic [13:0] REV_WORD = 14'h0101,
  parameter logic [13:0] DEV_WORD = 14'h0202,
  parameter logic [13:0] INFO_WORD = 14'h0000
)
(
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // indirect pointer port
  input wire logic [15:0] indirect_pointer,
  input wire logic ptr_rd,
  input wire logic ptr_wr,
  output logic [7:0] indirect_data_port,
  output logic ptr_ack,
  output logic ptr_reject,
  // programmer pins
  input wire logic pgm_req,
  input wire logic [1:0] pgm_op,
  input wire logic [15:0] pgm_addr,
  input wire logic [13:0] pgm_wdata,
  output logic pgm_ack,
  output logic pgm_refused,
  output logic [13:0] pgm_rdata,
  // core side
  output logic cpu_stall,
  output logic irq
);

  localparam int PW = $clog2(PFM_WORDS);
  localparam int DW = $clog2(DFM_BYTES);
  localparam int TW = $clog2(BULK_CYCLES + 1);

  // ----------------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------------
  logic [13:0] program_flash [PFM_WORDS];
  logic [13:0] uid [4];
  logic [13:0] cfg [5];
  logic [7:0] data_flash [DFM_BYTES];

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic region_select_bit;
  logic ctrl_rd;
  logic ctrl_wren;
  logic ctrl_free;
  logic [14:0] nvm_address;
  logic [13:0] nvm_data;
  logic [1:0] stat;
  logic [1:0] mask;
  logic [1:0] key_stage;
  nvap_state_t st;
  nvap_job_t job;
  logic [TW-1:0] tmr;
  nvap_region_t tgt_region;
  logic [13:0] tgt_idx;
  logic [13:0] tgt_data;
  logic tgt_prog;
  logic pg_req_m;
  logic pg_req_s;
  logic [1:0] pg_op_m;
  logic [1:0] pg_op_s;
  logic [15:0] pg_addr_m;
  logic [15:0] pg_addr_s;
  logic [13:0] pg_wdata_m;
  logic [13:0] pg_wdata_s;
  logic pg_taken;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic [13:0] idx_of(input nvap_region_t r,
                                         input logic [14:0] a);
    logic [13:0] i;
    case (r)
      RG_PFM: i = a[13:0];
      RG_UID: i = {12'h000, a[1:0]};
      RG_CFG: i = 14'(a - `NVAP_CFG_LO);
      RG_INFO: i = 14'(a - `NVAP_INFO_LO);
      RG_DFM: i = {6'h00, a[7:0]};
      default: i = 14'h0000;
    endcase
    return i;
  endfunction

  function automatic logic [13:0] word_at(input nvap_region_t r,
                                          input logic [13:0] i);
    logic [13:0] w;
    w = 14'h0000;
    case (r)
      RG_PFM:
        if (int'(i) < PFM_WORDS)
          w = program_flash[i[PW-1:0]];
      RG_UID: w = uid[i[1:0]];
      RG_REV: w = REV_WORD;
      RG_DEVID: w = DEV_WORD;
      RG_CFG: w = cfg[i[2:0]];
      RG_INFO: w = INFO_WORD;
      RG_DFM:
        if (int'(i) < DFM_BYTES)
          w = {6'h00, data_flash[i[DW-1:0]]};
      default: w = 14'h0000; // RULE17
    endcase
    return w;
  endfunction

  // ----------------------------------------------------------------------
  // decode of the three access paths
  // ----------------------------------------------------------------------
  nvap_region_t sw_region;
  nvap_region_t ptr_region;
  nvap_region_t pg_region;
  logic sw_wr_ok;
  logic pg_wr_ok;
  logic ptr_high;
  logic [14:0] ptr_addr15;

  assign ptr_high = indirect_pointer[15];
  // pointer 0x8000 and up is program flash word plus base
  assign ptr_addr15 = ptr_high ? {1'b0, indirect_pointer[13:0]} :
                                 indirect_pointer[14:0]; // RULE10

  nvap_decode u_dec_sw (
    .region_sel(region_select_bit),
    .addr(nvm_address),
    .region(sw_region),
    .writable(sw_wr_ok)
  );

  nvap_decode u_dec_ptr (
    .region_sel(!ptr_high),
    .addr(ptr_addr15),
    .region(ptr_region),
    .writable()
  );

  nvap_decode u_dec_pg (
    .region_sel(pg_addr_s[15]),
    .addr(pg_addr_s[14:0]),
    .region(pg_region),
    .writable(pg_wr_ok)
  );

  logic [13:0] sw_idx;
  logic [13:0] pg_idx;
  logic [13:0] ptr_word;
  assign sw_idx = idx_of(sw_region, nvm_address);
  assign pg_idx = idx_of(pg_region, pg_addr_s[14:0]);
  assign ptr_word = word_at(ptr_region, idx_of(ptr_region, ptr_addr15));

  // ----------------------------------------------------------------------
  // protection
  // ----------------------------------------------------------------------
  logic cp_on;
  logic cpd_on;
  logic [3:0] wp_on;
  logic sw_prot;
  assign cp_on = !cfg[`NVAP_CFG_CP_WORD][`NVAP_CP_BIT];
  assign cpd_on = !cfg[`NVAP_CFG_CP_WORD][`NVAP_CPD_BIT];
  assign wp_on = ~cfg[`NVAP_CFG_WP_WORD][3:0];
  assign sw_prot = (sw_region == RG_PFM && wp_on[0]) ||
                   (sw_region == RG_UID && wp_on[1]) ||
                   (sw_region == RG_CFG && wp_on[2]) ||
                   (sw_region == RG_DFM && wp_on[3]); // RULE4

  // ----------------------------------------------------------------------
  // start decisions
  // ----------------------------------------------------------------------
  logic wr_ctrl;
  logic sw_go;
  logic sw_ok;
  logic sw_start;
  logic sw_err;
  logic erase_ok;
  logic pg_new;
  logic pg_is_rd;
  logic pg_is_wr;
  logic pg_locked;
  logic pg_bad;
  logic pg_start;
  logic fin;

  assign wr_ctrl = reg_wr && reg_addr == `NVAP_REG_CTRL;
  // the start bit only counts right after both keys
  assign sw_go = wr_ctrl && reg_wdata[`NVAP_CTRL_WR] &&
                 reg_wdata[`NVAP_CTRL_WREN] && key_stage == 2'h2 &&
                 st == ST_IDLE; // RULE13
  // software may erase program rows, user ids and data bytes, never config
  assign erase_ok = sw_region == RG_PFM || sw_region == RG_UID ||
                    sw_region == RG_DFM; // RULE6
  assign sw_ok = sw_wr_ok && !sw_prot &&
                 (!reg_wdata[`NVAP_CTRL_FREE] || erase_ok); // RULE16
  assign sw_start = sw_go && sw_ok;
  assign sw_err = sw_go && !sw_ok && sw_region != RG_RSV; // RULE5 RULE17

  // software wins a tie; the programmer keeps its request up and retries
  assign pg_new = pg_req_s && !pg_taken && st == ST_IDLE && !sw_go;
  assign pg_is_rd = pg_op_s == `NVAP_PG_READ;
  assign pg_is_wr = pg_op_s == `NVAP_PG_WRITE;
  assign pg_locked = (pg_region == RG_PFM && cp_on) ||
                     (pg_region == RG_DFM && cpd_on); // RULE3
  assign pg_bad = ((pg_is_rd || pg_is_wr) &&
                   (pg_locked || pg_region == RG_NONE ||
                    pg_region == RG_RSV)) ||
                  (pg_is_wr && !pg_wr_ok); // RULE3
  assign pg_start = pg_new && !pg_bad && !pg_is_rd; // RULE7
  assign fin = st == ST_BUSY && tmr == '0; // RULE2

  // ----------------------------------------------------------------------
  // programmer pin synchronisers
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pg_req_m <= 1'b0;
      pg_req_s <= 1'b0;
      pg_op_m <= 2'h0;
      pg_op_s <= 2'h0;
      pg_addr_m <= 16'h0000;
      pg_addr_s <= 16'h0000;
      pg_wdata_m <= 14'h0000;
      pg_wdata_s <= 14'h0000;
    end
    else
    begin
      pg_req_m <= pgm_req;
      pg_req_s <= pg_req_m;
      pg_op_m <= pgm_op;
      pg_op_s <= pg_op_m;
      pg_addr_m <= pgm_addr;
      pg_addr_s <= pg_addr_m;
      pg_wdata_m <= pgm_wdata;
      pg_wdata_s <= pg_wdata_m;
    end
  end

  // ----------------------------------------------------------------------
  // write and erase engine
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st <= ST_IDLE;
      job <= JOB_WRITE;
      tmr <= '0;
      tgt_region <= RG_NONE;
      tgt_idx <= 14'h0000;
      tgt_data <= 14'h0000;
      tgt_prog <= 1'b0;
    end
    else
    begin
      case (st)
        ST_IDLE:
          if (sw_start)
          begin
            st <= ST_BUSY;
            job <= reg_wdata[`NVAP_CTRL_FREE] ? JOB_ERASE : JOB_WRITE;
            tmr <= TW'(PROG_CYCLES - 1); // RULE2
            tgt_region <= sw_region;
            tgt_idx <= sw_idx;
            tgt_data <= nvm_data;
            tgt_prog <= 1'b0;
          end
          else if (pg_start)
          begin
            st <= ST_BUSY;
            tgt_region <= pg_region;
            tgt_idx <= pg_idx;
            tgt_data <= pg_wdata_s;
            tgt_prog <= 1'b1;
            if (pg_is_wr)
            begin
              job <= JOB_WRITE;
              tmr <= TW'(PROG_CYCLES - 1); // RULE2
            end
            else
            begin
              job <= (pg_op_s == `NVAP_PG_BULK) ? JOB_BULK : JOB_BULK_CFG;
              tmr <= TW'(BULK_CYCLES - 1); // RULE2
            end
          end
        ST_BUSY:
          if (fin)
            st <= ST_IDLE;
          else
            tmr <= tmr - 1'b1;
        default: st <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // nonvolatile arrays
  // ----------------------------------------------------------------------
  logic [PW-1:0] row_base;
  assign row_base = tgt_idx[PW-1:0] & ~PW'(ROW_WORDS - 1);

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (int i = 0; i < PFM_WORDS; i++)
        program_flash[i] <= `NVAP_WORD_ERASED;
      for (int i = 0; i < 4; i++)
        uid[i] <= `NVAP_WORD_ERASED;
      for (int i = 0; i < 5; i++)
        cfg[i] <= `NVAP_WORD_ERASED;
      for (int i = 0; i < DFM_BYTES; i++)
        data_flash[i] <= `NVAP_BYTE_ERASED;
    end
    else if (fin)
    begin
      case (job)
        // flash words only program toward zero, so no write can lift
        // a protection bit back to its erased state
        JOB_WRITE:
          case (tgt_region)
            RG_PFM:
              program_flash[tgt_idx[PW-1:0]] <=
                program_flash[tgt_idx[PW-1:0]] & tgt_data; // RULE9
            RG_UID: uid[tgt_idx[1:0]] <= uid[tgt_idx[1:0]] & tgt_data;
            RG_CFG:
              cfg[tgt_idx[2:0]] <= cfg[tgt_idx[2:0]] & tgt_data; // RULE6
            RG_DFM:
              data_flash[tgt_idx[DW-1:0]] <= tgt_data[7:0]; // RULE1
            default: ;
          endcase
        JOB_ERASE:
          case (tgt_region)
            RG_PFM:
              for (int i = 0; i < ROW_WORDS; i++)
                program_flash[row_base + PW'(i)] <= `NVAP_WORD_ERASED;
            RG_UID:
              for (int i = 0; i < 4; i++)
                uid[i] <= `NVAP_WORD_ERASED;
            RG_DFM:
              data_flash[tgt_idx[DW-1:0]] <= `NVAP_BYTE_ERASED; // RULE1
            default: ;
          endcase
        JOB_BULK:
          for (int i = 0; i < PFM_WORDS; i++)
            program_flash[i] <= `NVAP_WORD_ERASED; // RULE7
        JOB_BULK_CFG:
        begin
          for (int i = 0; i < 5; i++)
            cfg[i] <= `NVAP_WORD_ERASED; // RULE6
          if (cp_on || cpd_on)
          begin
            for (int i = 0; i < PFM_WORDS; i++)
              program_flash[i] <= `NVAP_WORD_ERASED; // RULE8
            for (int i = 0; i < 4; i++)
              uid[i] <= `NVAP_WORD_ERASED; // RULE8
            for (int i = 0; i < DFM_BYTES; i++)
              data_flash[i] <= `NVAP_BYTE_ERASED; // RULE8
          end
        end
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      region_select_bit <= 1'b0;
      ctrl_rd <= 1'b0;
      ctrl_wren <= 1'b0;
      ctrl_free <= 1'b0;
      nvm_address <= 15'h0000;
      nvm_data <= 14'h0000;
      mask <= 2'h0;
      key_stage <= 2'h0;
    end
    else
    begin
      if (reg_wr)
      begin
        key_stage <= 2'h0;
        case (reg_addr)
          `NVAP_REG_CTRL:
          begin
            region_select_bit <= reg_wdata[`NVAP_CTRL_RSEL];
            ctrl_wren <= reg_wdata[`NVAP_CTRL_WREN];
            ctrl_free <= reg_wdata[`NVAP_CTRL_FREE];
            ctrl_rd <= reg_wdata[`NVAP_CTRL_RD];
          end
          `NVAP_REG_MASK: mask <= reg_wdata[1:0];
          `NVAP_REG_ADRL: nvm_address[7:0] <= reg_wdata;
          `NVAP_REG_ADRH: nvm_address[14:8] <= reg_wdata[6:0];
          `NVAP_REG_DATL: nvm_data[7:0] <= reg_wdata;
          `NVAP_REG_DATH: nvm_data[13:8] <= reg_wdata[5:0];
          `NVAP_REG_KEY:
            if (reg_wdata == `NVAP_KEY1)
              key_stage <= 2'h1;
            else if (reg_wdata == `NVAP_KEY2 && key_stage == 2'h1)
              key_stage <= 2'h2;
          default: ;
        endcase
      end
      if (ctrl_rd)
      begin
        nvm_data <= word_at(sw_region, sw_idx);
        ctrl_rd <= 1'b0; // RULE14
      end
    end
  end

  // ----------------------------------------------------------------------
  // interrupt status
  // ----------------------------------------------------------------------
  logic [1:0] next_stat;
  logic [1:0] stat_set;
  logic [1:0] stat_clr;

  always_comb
  begin
    stat_set = 2'h0;
    stat_set[`NVAP_STAT_DONE] = fin && !tgt_prog; // RULE15
    stat_set[`NVAP_STAT_ERR] = sw_err; // RULE5
    stat_clr = (reg_wr && reg_addr == `NVAP_REG_STAT) ? reg_wdata[1:0] :
               2'h0;
    // a new event wins over a clear in the same cycle
    next_stat = (stat & ~stat_clr) | stat_set;
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      stat <= 2'h0;
      irq <= 1'b0;
    end
    else
    begin
      stat <= next_stat;
      irq <= |(next_stat & mask); // RULE15
    end
  end

  // ----------------------------------------------------------------------
  // register read, pointer port, core stall
  // ----------------------------------------------------------------------
  logic wr_busy;
  assign wr_busy = st == ST_BUSY && !tgt_prog;

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      case (reg_addr)
        `NVAP_REG_CTRL:
          reg_rdata <= {1'b0, region_select_bit, 1'b0,
                        stat[`NVAP_STAT_ERR], ctrl_free, ctrl_wren,
                        wr_busy, ctrl_rd};
        `NVAP_REG_STAT: reg_rdata <= {6'h00, stat};
        `NVAP_REG_MASK: reg_rdata <= {6'h00, mask};
        `NVAP_REG_ADRL: reg_rdata <= nvm_address[7:0];
        `NVAP_REG_ADRH: reg_rdata <= {1'b0, nvm_address[14:8]};
        `NVAP_REG_DATL: reg_rdata <= nvm_data[7:0];
        `NVAP_REG_DATH: reg_rdata <= {2'h0, nvm_data[13:8]};
        `NVAP_REG_PROT: reg_rdata <= {2'h0, cpd_on, cp_on, wp_on};
        default: reg_rdata <= 8'h00;
      endcase
    else
      reg_rdata <= 8'h00;
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      indirect_data_port <= 8'h00;
      ptr_ack <= 1'b0;
      ptr_reject <= 1'b0;
      cpu_stall <= 1'b0;
    end
    else
    begin
      ptr_ack <= ptr_rd;
      ptr_reject <= ptr_wr; // RULE10
      // only program flash and data flash answer through the pointer
      if (ptr_rd && (ptr_region == RG_PFM || ptr_region == RG_DFM))
        indirect_data_port <= ptr_word[7:0]; // RULE10 RULE11
      else
        indirect_data_port <= 8'h00;
      cpu_stall <= sw_start || (wr_busy && !fin);
    end
  end

  // ----------------------------------------------------------------------
  // programmer answer, four phase
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pg_taken <= 1'b0;
      pgm_ack <= 1'b0;
      pgm_refused <= 1'b0;
      pgm_rdata <= 14'h0000;
    end
    else if (!pg_req_s)
    begin
      pg_taken <= 1'b0;
      pgm_ack <= 1'b0;
      pgm_refused <= 1'b0;
    end
    else
    begin
      if (pg_new)
      begin
        pg_taken <= 1'b1;
        pgm_refused <= pg_bad; // RULE3
        if (pg_bad || pg_is_rd)
          pgm_ack <= 1'b1;
        if (pg_is_rd && !pg_bad)
          pgm_rdata <= word_at(pg_region, pg_idx);
      end
      if (fin && tgt_prog)
        pgm_ack <= 1'b1;
    end
  end

endmodule

// [sim/nvap_monitor.sv]
// checker of the nvm access block ports
`timescale 1ns/1ps
module nvap_monitor
(
  // watched ports
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic ptr_rd,
  input wire logic ptr_wr,
  input wire logic [7:0] indirect_data_port,
  input wire logic ptr_ack,
  input wire logic ptr_reject,
  input wire logic pgm_req,
  input wire logic pgm_ack,
  input wire logic pgm_refused,
  input wire logic cpu_stall
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);
  a_rd_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("stray read data");
  a_ptr_ack: assert property (ptr_rd |=> ptr_ack)
    else $error("no pointer ack");
  a_ptr_idle: assert property (!ptr_rd |=> !ptr_ack)
    else $error("stray pointer ack");
  a_ptr_quiet: assert property (!ptr_rd |=>
    indirect_data_port == 8'h00)
    else $error("stray pointer data");
  a_ptr_reject: assert property (ptr_wr |=> ptr_reject)
    else $error("pointer write taken");
  a_stall_timed: assert property ($rose(cpu_stall) |-> cpu_stall[*4])
    else $error("stall too short");
  a_refuse_ack: assert property (pgm_refused |-> pgm_ack)
    else $error("refused without ack");
  a_ack_holds: assert property (pgm_ack && pgm_req |=> pgm_ack)
    else $error("ack dropped early");
  cover property ($rose(cpu_stall));
  cover property (pgm_refused);
  cover property (ptr_reject);
endmodule

bind nvap_top nvap_monitor i_nvap_monitor (.*);

// [sim/nvap_pgm_model.sv]
// programmer model on the four-phase request pins
`timescale 1ns/1ps
module nvap_pgm_model
(
  // clock
  input wire logic core_clk,
  // programmer pins
  output logic pgm_req,
  output logic [1:0] pgm_op,
  output logic [15:0] pgm_addr,
  output logic [13:0] pgm_wdata,
  input wire logic pgm_ack,
  input wire logic pgm_refused
);
  initial
  begin
    pgm_req = 1'b0;
    pgm_op = 2'h0;
    pgm_addr = 16'h0000;
    pgm_wdata = 14'h0000;
  end
  // pins are synchronised, so they settle well before the request
  task automatic run(input logic [1:0] op, input logic [15:0] a,
    output logic rf);
    pgm_op <= op;
    pgm_addr <= a;
    repeat (3) @(posedge core_clk);
    pgm_req <= 1'b1;
    for (int i = 0; i < 60 && pgm_ack !== 1'b1; i++) @(posedge core_clk);
    rf = pgm_refused;
    pgm_req <= 1'b0;
    for (int i = 0; i < 60 && pgm_ack !== 1'b0; i++) @(posedge core_clk);
    // released address and data pins never show the last value; pgm_op keeps it
    pgm_addr <= ~a;
    pgm_wdata <= ~pgm_wdata;
  endtask
endmodule

// [sim/nvap_top_tb_top.sv]
// self-checking bench for the nvm access block
`timescale 1ns/1ps
module nvap_top_tb_top;
  logic core_clk = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic ptr_rd = 1'b0, ptr_wr = 1'b0, rd_d = 1'b0, rf, pgm_req;
  logic ptr_ack, ptr_reject, pgm_ack, pgm_refused, cpu_stall, irq;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, indirect_data_port, x, y;
  logic [15:0] indirect_pointer = 16'h0000, pgm_addr;
  logic [13:0] pgm_wdata, pgm_rdata;
  logic [1:0] pgm_op;
  logic [31:0] seed = 32'h0000_0035;
  logic [7:0] rq[$], pq[$];
  int num_errors = 0, checks = 0;
  // short counts keep the run brief
  nvap_top #(.PFM_WORDS(64), .PROG_CYCLES(8), .BULK_CYCLES(16))
    i_nvap_top (.*);
  nvap_pgm_model i_nvap_pgm_model (.*);
  initial
  begin
    forever #4 core_clk = ~core_clk;
  end
  function automatic logic [7:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task automatic chk(input string n, input logic [15:0] e, g);
    checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= w;
    reg_rd <= !w;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    rq.push_back(e);
    bus(0, a, 8'h00);
  endtask
  task automatic adr(input logic [14:0] a);
    bus(1, 3, a[7:0]);
    bus(1, 4, {1'b0, a[14:8]});
  endtask
  task automatic job(input logic s, f, input logic [14:0] a, input [13:0] d);
    bus(1, 0, {1'b0, s, 6'h00});
    adr(a);
    bus(1, 5, d[7:0]);
    bus(1, 6, {2'h0, d[13:8]});
    bus(1, 7, 8'h55);
    bus(1, 7, 8'haa);
    bus(1, 0, {1'b0, s, 2'h0, f, 3'h6});
    for (int i = 0; i < 40 && cpu_stall !== 1'b0; i++) @(posedge core_clk);
    chk("cpu_stall", 0, cpu_stall);
  endtask
  task automatic rdw(input logic s, input logic [14:0] a, input [7:0] e);
    adr(a);
    bus(1, 0, {1'b0, s, 6'h01});
    rd(5, e);
  endtask
  task automatic pt(input logic [15:0] a, input logic [7:0] e);
    indirect_pointer <= a;
    ptr_rd <= 1'b1;
    @(posedge core_clk);
    ptr_rd <= 1'b0;
    pq.push_back(e);
    @(posedge core_clk);
  endtask
  // answers are matched against the oldest note
  always @(posedge core_clk)
  begin
    rd_d <= reg_rd;
    if (rd_d)
      chk("reg_rdata", rq.pop_front(), reg_rdata);
    if (ptr_ack === 1'b1)
      chk("ptr_data", pq.pop_front(), indirect_data_port);
  end
  task automatic results();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge core_clk);
    num_errors++;
    results();
  end
  initial
  begin
    repeat (3) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    rd(15, 8'h00);
    x = xs();
    y = xs();
    job(0, 0, 15'h0005, {6'h00, x});
    rdw(0, 15'h0005, x);
    rd(0, 8'h00);
    rd(1, 8'h01);
    bus(1, 1, 8'h03);
    pt(16'h8005, x);
    ptr_wr <= 1'b1;
    @(posedge core_clk);
    ptr_wr <= 1'b0;
    job(1, 0, 15'h7000, {6'h00, x});
    job(1, 0, 15'h7000, {6'h00, y});
    pt(16'h7000, y);
    rdw(1, 15'h0004, 8'h00);
    rdw(1, 15'h0005, 8'h01);
    $display("map test done");
    job(1, 0, 15'h000b, 14'h3ffe);
    job(1, 0, 15'h000a, 14'h3ffe);
    rd(8, 8'h11);
    bus(1, 1, 8'h03);
    bus(1, 2, 8'h02);
    job(0, 0, 15'h0005, 14'h0000);
    rd(1, 8'h02);
    chk("irq", 1, irq);
    job(0, 1, 15'h0005, 14'h0000);
    pt(16'h8005, x);
    bus(1, 1, 8'h03);
    chk("irq", 0, irq);
    i_nvap_pgm_model.run(2'h0, 16'h0005, rf);
    chk("refused", 1, rf);
    i_nvap_pgm_model.run(2'h0, 16'hf000, rf);
    chk("pgm_rdata", {6'h00, y}, pgm_rdata);
    i_nvap_pgm_model.run(2'h3, 16'h0000, rf);
    rd(8, 8'h00);
    pt(16'h8005, 8'hff);
    pt(16'h7000, 8'hff);
    $display("protection test done");
    results();
  end
endmodule
